// file: src/mies_defines.svh
`ifndef MIES_DEFINES_SVH
`define MIES_DEFINES_SVH

`define MIES_DATA_W      8
`define MIES_BIT_SEL_W   3
`define MIES_PAGE_W      4
`define MIES_ROM_ADDR_W  12
`define MIES_ROM_W       16
`define MIES_MSB         7
`define MIES_NIB_LO      3:0
`define MIES_NIB_HI      7:4
`define MIES_ROM_LO      7:0
`define MIES_ROM_HI      15:8
`define MIES_FILL_VALUE  8'hFF
`define MIES_ONE         8'h01
`define MIES_ZERO        8'h00
`define MIES_LAST_PAGE   4'hF
`define MIES_ACC_RST     8'h00
`define MIES_TABLE_READ_HIGH_BYTE_RST    8'h00
`define MIES_FLAGS_RST   4'h0
`define MIES_SKIP_CYCLES 2
`define MIES_TABLE_CYCLES 2

`endif

// file: src/mies_pkg.sv
`include "mies_defines.svh"
package mies_pkg;

	typedef enum logic [4:0] {
		OP_NOP                       = 5'h00,
		OP_DEC_TO_ACC_SKIP_ZERO      = 5'h01,
		OP_SET_BYTE                  = 5'h02,
		OP_SET_BIT                   = 5'h03,
		OP_INC_SKIP_ZERO             = 5'h04,
		OP_INC_TO_ACC_SKIP_ZERO      = 5'h05,
		OP_SKIP_BIT_NONZERO          = 5'h06,
		OP_SUB_ACC                   = 5'h07,
		OP_MINUS_INTO_MEMORY         = 5'h08,
		OP_SUB_IMM                   = 5'h09,
		OP_NIBBLE_SWAP               = 5'h0A,
		OP_NIBBLE_EXCHANGE_TO_ACC    = 5'h0B,
		OP_SKIP_WHEN_ZERO            = 5'h0C,
		OP_MOVE_ACC_SKIP_ZERO        = 5'h0D,
		OP_SKIP_BIT_ZERO             = 5'h0E,
		OP_TABLE_READ_PAGE_CURRENT   = 5'h0F,
		OP_TABLE_READ_PAGE_LAST      = 5'h10,
		OP_XOR_ACC                   = 5'h11,
		OP_EXCLUSIVE_OR_MEMORY       = 5'h12,
		OP_XOR_IMM                   = 5'h13
	} mies_op_t;

	typedef enum logic [1:0] {
		ST_RUN   = 2'b00,
		ST_DUMMY = 2'b01,
		ST_TABLE = 2'b10
	} mies_state_t;

	typedef struct packed {
		logic                       valid;
		mies_op_t                   op;
		logic [`MIES_DATA_W-1:0]    addr;
		logic [`MIES_BIT_SEL_W-1:0] bit_sel;
		logic [`MIES_DATA_W-1:0]    imm;
	} mies_insn_t;

	typedef struct packed {
		logic overflow_flag;
		logic zero_flag;
		logic aux_carry_flag;
		logic carry_flag;
	} mies_flags_t;

	typedef struct packed {
		logic                    we;
		logic [`MIES_DATA_W-1:0] addr;
		logic [`MIES_DATA_W-1:0] data;
	} mies_mem_wr_t;

	typedef struct packed {
		logic [`MIES_DATA_W-1:0] result;
		logic                    acc_we;
		logic                    mem_we;
		logic                    skip;
		logic                    arith_upd;
		logic                    z_upd;
		mies_flags_t             flags;
	} mies_alu_out_t;

	function automatic logic [`MIES_DATA_W-1:0] mies_bit_mask(
		input logic [`MIES_BIT_SEL_W-1:0] sel);
		mies_bit_mask = `MIES_ONE << sel;
	endfunction

	function automatic logic [`MIES_DATA_W-1:0] mies_swap(
		input logic [`MIES_DATA_W-1:0] v);
		mies_swap = {v[`MIES_NIB_LO], v[`MIES_NIB_HI]};
	endfunction

endpackage

// file: src/mies_alu.sv
`timescale 1ns/1ps
`include "mies_defines.svh"
module mies_alu
	import mies_pkg::*;
(
	// Instruction and operands
	input  wire mies_insn_t              insn,
	input  wire logic [`MIES_DATA_W-1:0] operand,
	input  wire logic [`MIES_DATA_W-1:0] acc,
	// Result
	output mies_alu_out_t                alu_out
);
	logic [`MIES_DATA_W-1:0] sub_src;
	logic [`MIES_DATA_W:0]   diff;
	logic [4:0]              nib_diff;
	logic [`MIES_DATA_W-1:0] mask;

	// Subtract as add of the inverted operand plus one
	assign sub_src  = (insn.op == OP_SUB_IMM) ? insn.imm : operand;
	assign diff     = {1'b0, acc} + {1'b0, ~sub_src} + 9'h001;
	assign nib_diff = {1'b0, acc[`MIES_NIB_LO]}
		+ {1'b0, ~sub_src[`MIES_NIB_LO]} + 5'h01;
	assign mask     = mies_bit_mask(insn.bit_sel);

	always_comb begin
		alu_out = '0;
		unique case (insn.op)
			OP_DEC_TO_ACC_SKIP_ZERO: begin
				alu_out.result = operand - `MIES_ONE;
				alu_out.acc_we = 1'b1;
				alu_out.skip   = (operand == `MIES_ONE);
			end
			OP_SET_BYTE: begin
				alu_out.result = `MIES_FILL_VALUE;
				alu_out.mem_we = 1'b1;
			end
			OP_SET_BIT: begin
				alu_out.result = operand | mask;
				alu_out.mem_we = 1'b1;
			end
			OP_INC_SKIP_ZERO, OP_INC_TO_ACC_SKIP_ZERO: begin
				alu_out.result = operand + `MIES_ONE;
				alu_out.mem_we = (insn.op == OP_INC_SKIP_ZERO);
				alu_out.acc_we = (insn.op == OP_INC_TO_ACC_SKIP_ZERO);
				alu_out.skip   = (operand == `MIES_FILL_VALUE);
			end
			OP_SKIP_BIT_NONZERO: alu_out.skip = |(operand & mask);
			OP_SKIP_BIT_ZERO:    alu_out.skip = ~|(operand & mask);
			OP_SUB_ACC, OP_SUB_IMM, OP_MINUS_INTO_MEMORY: begin
				alu_out.result    = diff[`MIES_DATA_W-1:0];
				alu_out.acc_we    = (insn.op != OP_MINUS_INTO_MEMORY);
				alu_out.mem_we    = (insn.op == OP_MINUS_INTO_MEMORY);
				alu_out.arith_upd = 1'b1;
				alu_out.z_upd     = 1'b1;
			end
			OP_NIBBLE_SWAP, OP_NIBBLE_EXCHANGE_TO_ACC: begin
				alu_out.result = mies_swap(operand);
				alu_out.mem_we = (insn.op == OP_NIBBLE_SWAP);
				alu_out.acc_we = (insn.op == OP_NIBBLE_EXCHANGE_TO_ACC);
			end
			OP_SKIP_WHEN_ZERO: alu_out.skip = (operand == `MIES_ZERO);
			OP_MOVE_ACC_SKIP_ZERO: begin
				alu_out.result = operand;
				alu_out.acc_we = 1'b1;
				alu_out.skip   = (operand == `MIES_ZERO);
			end
			OP_XOR_ACC, OP_XOR_IMM, OP_EXCLUSIVE_OR_MEMORY: begin
				alu_out.result = acc ^ ((insn.op == OP_XOR_IMM) ?
					insn.imm : operand);
				alu_out.acc_we = (insn.op != OP_EXCLUSIVE_OR_MEMORY);
				alu_out.mem_we = (insn.op == OP_EXCLUSIVE_OR_MEMORY);
				alu_out.z_upd  = 1'b1;
			end
			OP_NOP, OP_TABLE_READ_PAGE_CURRENT, OP_TABLE_READ_PAGE_LAST: begin
				alu_out.result = `MIES_ZERO;
			end
			default: alu_out.result = `MIES_ZERO;
		endcase
		alu_out.flags.zero_flag      = (alu_out.result == `MIES_ZERO);
		alu_out.flags.carry_flag     = diff[`MIES_DATA_W];
		alu_out.flags.aux_carry_flag = nib_diff[4];
		// Overflow: like signs in, unlike sign out
		alu_out.flags.overflow_flag  =
			(acc[`MIES_MSB] == ~sub_src[`MIES_MSB])
			&& (diff[`MIES_MSB] != acc[`MIES_MSB]);
	end

endmodule // mies_alu

// file: src/mies_table.sv
`timescale 1ns/1ps
`include "mies_defines.svh"
module mies_table
	import mies_pkg::*;
(
	// Selection
	input  wire mies_op_t                    op,
	input  wire logic                        high_ptr_option_en,
	// Pointers
	input  wire logic [`MIES_DATA_W-1:0]     table_pointer_low,
	input  wire logic [`MIES_PAGE_W-1:0]     table_pointer_high,
	input  wire logic [`MIES_PAGE_W-1:0]     pc_page,
	// Program word address
	output logic [`MIES_ROM_ADDR_W-1:0]      table_addr
);
	logic [`MIES_PAGE_W-1:0] page;

	always_comb begin
		if (op == OP_TABLE_READ_PAGE_LAST) begin
			page = `MIES_LAST_PAGE;
		end else if (high_ptr_option_en) begin
			page = table_pointer_high;
		end else begin
			page = pc_page;
		end
	end

	assign table_addr = {page, table_pointer_low};

endmodule // mies_table

// file: src/mies_exec.sv
`timescale 1ns/1ps
`include "mies_defines.svh"
module mies_exec
	import mies_pkg::*;
(
	// Clock and reset
	input  wire logic                        core_clk,
	input  wire logic                        reset_n,
	// Decoded instruction from fetch
	input  wire mies_insn_t                  insn,
	output logic                             insn_ready,
	output logic                             skip_discard_reg,
	// Data memory
	input  wire logic [`MIES_DATA_W-1:0]     mem_rdata,
	output mies_mem_wr_t                     mem_wr_reg,
	// Core state
	output logic [`MIES_DATA_W-1:0]          accumulator_reg,
	output mies_flags_t                      status_flags_reg,
	output logic [`MIES_DATA_W-1:0]          table_read_high_byte_reg,
	// Table pointers and option
	input  wire logic                        high_ptr_option_en,
	input  wire logic [`MIES_DATA_W-1:0]     table_pointer_low,
	input  wire logic [`MIES_PAGE_W-1:0]     table_pointer_high,
	input  wire logic [`MIES_PAGE_W-1:0]     pc_page,
	// Program memory read port
	output logic                             rom_rd_en_reg,
	output logic [`MIES_ROM_ADDR_W-1:0]      rom_addr_reg,
	input  wire logic [`MIES_ROM_W-1:0]      rom_rdata
);
	mies_state_t             state_reg;
	mies_alu_out_t           alu_out;
	logic                    accept;
	logic                    is_table;
	logic [`MIES_DATA_W-1:0] operand;
	logic [`MIES_DATA_W-1:0] table_dest_reg;
	logic [`MIES_ROM_ADDR_W-1:0] table_addr;

	assign insn_ready = (state_reg == ST_RUN);
	assign accept     = insn.valid && insn_ready;
	assign is_table   = (insn.op == OP_TABLE_READ_PAGE_CURRENT)
		|| (insn.op == OP_TABLE_READ_PAGE_LAST);

	// Write lands one cycle late, so forward it to a reader of the same byte
	assign operand = (mem_wr_reg.we && mem_wr_reg.addr == insn.addr) ?
		mem_wr_reg.data : mem_rdata;

	mies_alu u_alu (
		.insn    (insn),
		.operand (operand),
		.acc     (accumulator_reg),
		.alu_out (alu_out)
	);

	mies_table u_table (
		.op                 (insn.op),
		.high_ptr_option_en (high_ptr_option_en),
		.table_pointer_low  (table_pointer_low),
		.table_pointer_high (table_pointer_high),
		.pc_page            (pc_page),
		.table_addr         (table_addr)
	);

	// Sequencing: dummy cycle after a taken skip, wait cycle for table data
	always_ff @(posedge core_clk or negedge reset_n) begin
		if (!reset_n) begin
			state_reg <= ST_RUN;
		end else begin
			unique case (state_reg)
				ST_RUN: begin
					if (accept && alu_out.skip) begin
						state_reg <= ST_DUMMY;
					end else if (accept && is_table) begin
						state_reg <= ST_TABLE;
					end
				end
				ST_DUMMY: state_reg <= ST_RUN;
				ST_TABLE: state_reg <= ST_RUN;
				default:  state_reg <= ST_RUN;
			endcase
		end
	end

	// Prefetched word is thrown away while this pulse is high
	always_ff @(posedge core_clk or negedge reset_n) begin
		if (!reset_n) begin
			skip_discard_reg <= 1'b0;
		end else begin
			skip_discard_reg <= accept && alu_out.skip;
		end
	end

	always_ff @(posedge core_clk or negedge reset_n) begin
		if (!reset_n) begin
			accumulator_reg <= `MIES_ACC_RST;
		end else if (accept && alu_out.acc_we) begin
			accumulator_reg <= alu_out.result;
		end
	end

	always_ff @(posedge core_clk or negedge reset_n) begin
		if (!reset_n) begin
			status_flags_reg <= `MIES_FLAGS_RST;
		end else if (accept) begin
			if (alu_out.arith_upd) begin
				status_flags_reg <= alu_out.flags;
			end else if (alu_out.z_upd) begin
				status_flags_reg.zero_flag <= alu_out.flags.zero_flag;
			end
		end
	end

	// Memory write port, also carries the low byte of a table read
	always_ff @(posedge core_clk or negedge reset_n) begin
		if (!reset_n) begin
			mem_wr_reg <= '0;
		end else if (state_reg == ST_TABLE) begin
			mem_wr_reg.we   <= 1'b1;
			mem_wr_reg.addr <= table_dest_reg;
			mem_wr_reg.data <= rom_rdata[`MIES_ROM_LO];
		end else begin
			mem_wr_reg.we   <= accept && alu_out.mem_we;
			mem_wr_reg.addr <= insn.addr;
			mem_wr_reg.data <= alu_out.result;
		end
	end

	always_ff @(posedge core_clk or negedge reset_n) begin
		if (!reset_n) begin
			table_read_high_byte_reg <= `MIES_TABLE_READ_HIGH_BYTE_RST;
		end else if (state_reg == ST_TABLE) begin
			table_read_high_byte_reg <= rom_rdata[`MIES_ROM_HI];
		end
	end

	// Program memory answers one cycle after the registered address
	always_ff @(posedge core_clk or negedge reset_n) begin
		if (!reset_n) begin
			rom_rd_en_reg  <= 1'b0;
			rom_addr_reg   <= '0;
			table_dest_reg <= `MIES_ZERO;
		end else begin
			rom_rd_en_reg <= accept && is_table;
			if (accept && is_table) begin
				rom_addr_reg   <= table_addr;
				table_dest_reg <= insn.addr;
			end
		end
	end

	default clocking cb @(posedge core_clk); endclocking
	default disable iff (!reset_n);

	a_dec_acc_result: assert property (
		accept && insn.op == OP_DEC_TO_ACC_SKIP_ZERO |=>
		accumulator_reg == $past(operand) - `MIES_ONE && !mem_wr_reg.we
		&& skip_discard_reg == ($past(operand) == `MIES_ONE))
		else $error("decrement to accumulator wrong");

	a_fill_byte: assert property (
		accept && insn.op == OP_SET_BYTE |=> mem_wr_reg.we
		&& mem_wr_reg.data == `MIES_FILL_VALUE
		&& mem_wr_reg.addr == $past(insn.addr))
		else $error("byte fill wrong");

	a_set_one_bit: assert property (
		accept && insn.op == OP_SET_BIT |=> mem_wr_reg.we
		&& mem_wr_reg.data == ($past(operand)
		| mies_bit_mask($past(insn.bit_sel))))
		else $error("bit set wrong");

	a_inc_mem_skip: assert property (
		accept && insn.op == OP_INC_SKIP_ZERO |=> mem_wr_reg.we
		&& mem_wr_reg.data == $past(operand) + `MIES_ONE
		&& skip_discard_reg == (mem_wr_reg.data == `MIES_ZERO))
		else $error("increment with skip wrong");

	a_inc_acc_skip: assert property (
		accept && insn.op == OP_INC_TO_ACC_SKIP_ZERO |=>
		accumulator_reg == $past(operand) + `MIES_ONE && !mem_wr_reg.we
		&& skip_discard_reg == (accumulator_reg == `MIES_ZERO))
		else $error("increment to accumulator wrong");

	a_bit_set_skip: assert property (
		accept && insn.op == OP_SKIP_BIT_NONZERO |=> !mem_wr_reg.we
		&& $stable(accumulator_reg)
		&& skip_discard_reg == $past(operand[insn.bit_sel]))
		else $error("bit nonzero test wrong");

	a_skip_dummy: assert property (
		skip_discard_reg |-> !insn_ready ##1 insn_ready)
		else $error("skip dummy cycle wrong");

	a_no_skip_one: assert property (
		accept && !alu_out.skip && !is_table |=> insn_ready
		&& !skip_discard_reg)
		else $error("unskipped instruction stalled");

	a_sub_flags: assert property (
		accept && insn.op == OP_SUB_ACC |=>
		accumulator_reg == $past(accumulator_reg) - $past(operand)
		&& status_flags_reg.carry_flag
		== ($past(accumulator_reg) >= $past(operand))
		&& status_flags_reg.zero_flag == (accumulator_reg == `MIES_ZERO))
		else $error("subtract wrong");

	a_sub_to_mem: assert property (
		accept && insn.op == OP_MINUS_INTO_MEMORY |=> mem_wr_reg.we
		&& mem_wr_reg.data == $past(accumulator_reg) - $past(operand)
		&& $stable(accumulator_reg))
		else $error("subtract to memory wrong");

	a_swap_mem: assert property (
		accept && insn.op == OP_NIBBLE_SWAP |=> mem_wr_reg.we
		&& mem_wr_reg.data == mies_swap($past(operand)))
		else $error("nibble swap wrong");

	a_swap_acc: assert property (
		accept && insn.op == OP_NIBBLE_EXCHANGE_TO_ACC |=> !mem_wr_reg.we
		&& accumulator_reg == mies_swap($past(operand)))
		else $error("nibble swap to accumulator wrong");

	a_byte_zero: assert property (
		accept && insn.op == OP_SKIP_WHEN_ZERO && operand == `MIES_ZERO
		|=> skip_discard_reg && !insn_ready ##1 insn_ready)
		else $error("byte zero skip wrong");

	a_move_test: assert property (
		accept && insn.op == OP_MOVE_ACC_SKIP_ZERO |=>
		accumulator_reg == $past(operand)
		&& skip_discard_reg == (accumulator_reg == `MIES_ZERO))
		else $error("move and test wrong");

	a_bit_clear_skip: assert property (
		accept && insn.op == OP_SKIP_BIT_ZERO |=> !mem_wr_reg.we
		&& skip_discard_reg == !$past(operand[insn.bit_sel]))
		else $error("bit zero test wrong");

	a_table_high_ptr: assert property (
		accept && insn.op == OP_TABLE_READ_PAGE_CURRENT && high_ptr_option_en
		|=> rom_rd_en_reg && !insn_ready && rom_addr_reg
		== {$past(table_pointer_high), $past(table_pointer_low)}
		##1 mem_wr_reg.we && mem_wr_reg.data == $past(rom_rdata[7:0])
		&& table_read_high_byte_reg == $past(rom_rdata[15:8]))
		else $error("table read with high pointer wrong");

	a_table_cur_page: assert property (
		accept && insn.op == OP_TABLE_READ_PAGE_CURRENT && !high_ptr_option_en
		|=> rom_addr_reg == {$past(pc_page), $past(table_pointer_low)}
		##1 table_read_high_byte_reg == $past(rom_rdata[15:8]))
		else $error("table read in current page wrong");

	a_table_last: assert property (
		accept && insn.op == OP_TABLE_READ_PAGE_LAST |=> rom_rd_en_reg
		&& rom_addr_reg == {`MIES_LAST_PAGE, $past(table_pointer_low)}
		##1 mem_wr_reg.addr == $past(table_dest_reg) && mem_wr_reg.we)
		else $error("last page table read wrong");

	a_xor_acc: assert property (
		accept && insn.op == OP_XOR_ACC |=>
		accumulator_reg == ($past(accumulator_reg) ^ $past(operand))
		&& status_flags_reg.zero_flag == (accumulator_reg == `MIES_ZERO))
		else $error("xor to accumulator wrong");

	a_xor_mem: assert property (
		accept && insn.op == OP_EXCLUSIVE_OR_MEMORY |=> mem_wr_reg.we
		&& mem_wr_reg.data == ($past(accumulator_reg) ^ $past(operand))
		&& status_flags_reg.zero_flag == (mem_wr_reg.data == `MIES_ZERO))
		else $error("xor to memory wrong");

	a_xor_imm: assert property (
		accept && insn.op == OP_XOR_IMM |=>
		accumulator_reg == ($past(accumulator_reg) ^ $past(insn.imm))
		&& status_flags_reg.zero_flag == (accumulator_reg == `MIES_ZERO))
		else $error("xor immediate wrong");

	a_skip_pulse_one: assert property (
		skip_discard_reg |=> !skip_discard_reg)
		else $error("skip pulse longer than one cycle");

	a_dummy_no_effect: assert property (
		state_reg == ST_DUMMY |=> !mem_wr_reg.we && !skip_discard_reg
		&& $stable(accumulator_reg) && $stable(status_flags_reg))
		else $error("dummy cycle changed state");

	a_step_flags_kept: assert property (
		accept && insn.op inside {OP_DEC_TO_ACC_SKIP_ZERO,
		OP_INC_SKIP_ZERO, OP_INC_TO_ACC_SKIP_ZERO} |=>
		$stable(status_flags_reg))
		else $error("increment or decrement touched flags");

	a_test_keeps_data: assert property (
		accept && insn.op inside {OP_SKIP_BIT_ZERO, OP_SKIP_BIT_NONZERO,
		OP_SKIP_WHEN_ZERO} |=> !mem_wr_reg.we
		&& $stable(accumulator_reg) && $stable(status_flags_reg))
		else $error("skip test modified data");

	a_table_wait_one: assert property (
		rom_rd_en_reg |-> !insn_ready ##1 insn_ready && !rom_rd_en_reg)
		else $error("table read wait cycle wrong");

	a_idle_op_quiet: assert property (
		accept && insn.op == OP_NOP |=> !mem_wr_reg.we
		&& !skip_discard_reg && $stable(accumulator_reg)
		&& $stable(status_flags_reg))
		else $error("no-operation changed state");

endmodule // mies_exec

// file: tb/mies_exec_tb_top.sv
`timescale 1ns/1ps
`include "mies_defines.svh"
module mies_exec_tb_top
	import mies_pkg::*;
;
	logic         core_clk;
	logic         reset_n;
	mies_insn_t   insn;
	logic         insn_ready;
	logic         skip_discard_reg;
	logic [7:0]   mem_rdata;
	mies_mem_wr_t mem_wr_reg;
	logic [7:0]   accumulator_reg;
	mies_flags_t  status_flags_reg;
	logic [7:0]   table_read_high_byte_reg;
	logic         high_ptr_option_en;
	logic [7:0]   table_pointer_low;
	logic [3:0]   table_pointer_high;
	logic [3:0]   pc_page;
	logic         rom_rd_en_reg;
	logic [11:0]  rom_addr_reg;
	logic [15:0]  rom_rdata;
	int           num_errors;
	int           check_count;
	logic [7:0]   pa [5] = '{8'h50, 8'h30, 8'h80, 8'h05, 8'h7F};
	logic [7:0]   pm [5] = '{8'h30, 8'h50, 8'h01, 8'h05, 8'hFF};

	mies_exec dut (
		.core_clk                 (core_clk),
		.reset_n                  (reset_n),
		.insn                     (insn),
		.insn_ready               (insn_ready),
		.skip_discard_reg         (skip_discard_reg),
		.mem_rdata                (mem_rdata),
		.mem_wr_reg               (mem_wr_reg),
		.accumulator_reg          (accumulator_reg),
		.status_flags_reg         (status_flags_reg),
		.table_read_high_byte_reg (table_read_high_byte_reg),
		.high_ptr_option_en       (high_ptr_option_en),
		.table_pointer_low        (table_pointer_low),
		.table_pointer_high       (table_pointer_high),
		.pc_page                  (pc_page),
		.rom_rd_en_reg            (rom_rd_en_reg),
		.rom_addr_reg             (rom_addr_reg),
		.rom_rdata                (rom_rdata)
	);

	initial begin
		core_clk = 1'b0;
		forever #10 core_clk = ~core_clk;
	end

	task automatic test_done();
		if (num_errors == 0 && check_count > 0) begin
			$display("TEST PASSED");
		end else begin
			$display("TEST FAILED");
		end
		$finish;
	endtask

	task automatic check(input logic [15:0] seen, input logic [15:0] exp);
		check_count++;
		if (seen !== exp) begin
			num_errors++;
			$display("[FAIL] t=%0t seen=%h exp=%h", $time, seen, exp);
		end
	endtask

	// Presents one instruction, returns one cycle after it was taken
	task automatic run(input mies_op_t op, input logic [7:0] a,
		input logic [2:0] b, input logic [7:0] imm, input logic [7:0] m);
		int n;
		n = 0;
		@(posedge core_clk);
		#1;
		insn.valid = 1'b1;
		insn.op = op;
		insn.addr = a;
		insn.bit_sel = b;
		insn.imm = imm;
		mem_rdata = m;
		while (insn_ready !== 1'b1 && n < 8) begin
			@(posedge core_clk);
			#1;
			n++;
		end
		@(posedge core_clk);
		#1;
		insn.valid = 1'b0;
	endtask

	task automatic set_acc(input logic [7:0] v);
		run(OP_MOVE_ACC_SKIP_ZERO, 8'h10, 3'h0, 8'h00, v);
	endtask

	task automatic chk_skip(input logic s);
		check(16'(skip_discard_reg), 16'(s));
		check(16'(insn_ready), 16'(!s));
	endtask

	task automatic chk_wr(input logic we, input logic [7:0] a,
		input logic [7:0] d);
		check(16'(mem_wr_reg.we), 16'(we));
		if (we) begin
			check(16'(mem_wr_reg.addr), 16'(a));
			check(16'(mem_wr_reg.data), 16'(d));
		end
	endtask

	function automatic logic [3:0] sub_flags(input logic [7:0] a, m);
		logic [8:0] r;
		logic [4:0] h;
		r = {1'b0, a} + {1'b0, ~m} + 9'h001;
		h = {1'b0, a[3:0]} + {1'b0, ~m[3:0]} + 5'h01;
		sub_flags = {(a[7] != m[7]) && (r[7] != a[7]), r[7:0] == 8'h00,
			h[4], r[8]};
	endfunction

	task automatic inc_dec_tests();
		logic [7:0] ms [3] = '{8'h01, 8'h05, 8'hFF};
		foreach (ms[i]) begin
			run(OP_DEC_TO_ACC_SKIP_ZERO, 8'h20, 3'h0, 8'h00, ms[i]);
			check(16'(accumulator_reg), 16'(ms[i] - 8'h01));
			chk_wr(1'b0, 8'h20, 8'h00);
			chk_skip(ms[i] == 8'h01);
			run(OP_INC_SKIP_ZERO, 8'h22, 3'h0, 8'h00, ms[i]);
			chk_wr(1'b1, 8'h22, ms[i] + 8'h01);
			chk_skip(ms[i] == 8'hFF);
			run(OP_INC_TO_ACC_SKIP_ZERO, 8'h23, 3'h0, 8'h00, ms[i]);
			check(16'(accumulator_reg), 16'(8'(ms[i] + 8'h01)));
			chk_wr(1'b0, 8'h23, 8'h00);
			chk_skip(ms[i] == 8'hFF);
		end
	endtask

	task automatic bit_tests();
		run(OP_SET_BYTE, 8'h30, 3'h0, 8'h00, 8'h12);
		chk_wr(1'b1, 8'h30, 8'hFF);
		for (int b = 0; b < 8; b++) begin
			run(OP_SET_BIT, 8'h31, 3'(b), 8'h00, 8'h5A);
			chk_wr(1'b1, 8'h31, 8'h5A | (8'h01 << b));
			run(OP_SKIP_BIT_NONZERO, 8'h32, 3'(b), 8'h00, 8'hA5);
			chk_wr(1'b0, 8'h32, 8'h00);
			chk_skip(8'hA5 >> b & 8'h01);
			run(OP_SKIP_BIT_ZERO, 8'h33, 3'(b), 8'h00, 8'hA5);
			chk_wr(1'b0, 8'h33, 8'h00);
			chk_skip(!(8'hA5 >> b & 8'h01));
		end
	endtask

	task automatic sub_tests();
		foreach (pa[i]) begin
			set_acc(pa[i]);
			run(OP_SUB_ACC, 8'h40, 3'h0, 8'h00, pm[i]);
			check(16'(accumulator_reg), 16'(8'(pa[i] - pm[i])));
			check(16'(status_flags_reg), 16'(sub_flags(pa[i], pm[i])));
			set_acc(pa[i]);
			run(OP_MINUS_INTO_MEMORY, 8'h41, 3'h0, 8'h00, pm[i]);
			chk_wr(1'b1, 8'h41, pa[i] - pm[i]);
			check(16'(accumulator_reg), 16'(pa[i]));
			check(16'(status_flags_reg), 16'(sub_flags(pa[i], pm[i])));
			set_acc(pa[i]);
			run(OP_SUB_IMM, 8'h42, 3'h0, pm[i], 8'hEE);
			check(16'(accumulator_reg), 16'(8'(pa[i] - pm[i])));
		end
	endtask

	task automatic move_tests();
		run(OP_NIBBLE_SWAP, 8'h50, 3'h0, 8'h00, 8'h3C);
		chk_wr(1'b1, 8'h50, 8'hC3);
		run(OP_NIBBLE_EXCHANGE_TO_ACC, 8'h51, 3'h0, 8'h00, 8'hA7);
		check(16'(accumulator_reg), 16'h007A);
		chk_wr(1'b0, 8'h51, 8'h00);
		run(OP_SKIP_WHEN_ZERO, 8'h52, 3'h0, 8'h00, 8'h01);
		chk_skip(1'b0);
		run(OP_MOVE_ACC_SKIP_ZERO, 8'h53, 3'h0, 8'h00, 8'h80);
		check(16'(accumulator_reg), 16'h0080);
		chk_skip(1'b0);
		run(OP_NOP, 8'h54, 3'h0, 8'h00, 8'h00);
		check(16'(accumulator_reg), 16'h0080);
		chk_wr(1'b0, 8'h54, 8'h00);
		chk_skip(1'b0);
		run(mies_op_t'(5'h1F), 8'h54, 3'h0, 8'h00, 8'h00);
		check(16'(accumulator_reg), 16'h0080);
		chk_wr(1'b0, 8'h54, 8'h00);
		chk_skip(1'b0);
		run(OP_MOVE_ACC_SKIP_ZERO, 8'h53, 3'h0, 8'h00, 8'h00);
		check(16'(accumulator_reg), 16'h0000);
		chk_skip(1'b1);
	endtask

	// Instruction held through the dummy cycle must not be taken early
	task automatic skip_hold_test();
		set_acc(8'h0F);
		@(posedge core_clk);
		#1;
		insn.valid = 1'b1;
		insn.op = OP_SKIP_WHEN_ZERO;
		insn.addr = 8'h21;
		mem_rdata = 8'h00;
		@(posedge core_clk);
		#1;
		insn.op = OP_XOR_IMM;
		insn.imm = 8'hFF;
		chk_skip(1'b1);
		@(posedge core_clk);
		#1;
		check(16'(accumulator_reg), 16'h000F);
		chk_skip(1'b0);
		@(posedge core_clk);
		#1;
		insn.valid = 1'b0;
		check(16'(accumulator_reg), 16'h00F0);
	endtask

	task automatic table_rd(input mies_op_t op, input logic opt,
		input logic [11:0] ea, input logic [15:0] word);
		high_ptr_option_en = opt;
		run(op, 8'h55, 3'h0, 8'h00, 8'h00);
		check(16'(rom_rd_en_reg), 16'h0001);
		check(16'(rom_addr_reg), 16'(ea));
		check(16'(insn_ready), 16'h0000);
		rom_rdata = word;
		@(posedge core_clk);
		#1;
		rom_rdata = ~word;
		chk_wr(1'b1, 8'h55, word[7:0]);
		check(16'(table_read_high_byte_reg), 16'(word[15:8]));
		check(16'(rom_rd_en_reg), 16'h0000);
	endtask

	task automatic xor_tests();
		set_acc(8'h3C);
		run(OP_XOR_ACC, 8'h60, 3'h0, 8'h00, 8'h0F);
		check(16'(accumulator_reg), 16'h0033);
		check(16'(status_flags_reg.zero_flag), 16'h0000);
		run(OP_XOR_ACC, 8'h60, 3'h0, 8'h00, 8'h33);
		check(16'(status_flags_reg.zero_flag), 16'h0001);
		set_acc(8'hA5);
		run(OP_EXCLUSIVE_OR_MEMORY, 8'h61, 3'h0, 8'h00, 8'h5A);
		chk_wr(1'b1, 8'h61, 8'hFF);
		check(16'(accumulator_reg), 16'h00A5);
		check(16'(status_flags_reg.zero_flag), 16'h0000);
		run(OP_XOR_IMM, 8'h62, 3'h0, 8'hA5, 8'h00);
		check(16'(accumulator_reg), 16'h0000);
		check(16'(status_flags_reg.zero_flag), 16'h0001);
	endtask

	// Mid-run reset must clear the accumulator, flags and table high byte and leave the core ready before the next instruction
	task automatic reset_test();
		@(posedge core_clk);
		#1;
		reset_n = 1'b0;
		@(posedge core_clk);
		#1;
		check(16'(accumulator_reg), 16'h0000);
		check(16'(status_flags_reg), 16'h0000);
		check(16'(table_read_high_byte_reg), 16'h0000);
		check(16'(insn_ready), 16'h0001);
		reset_n = 1'b1;
		run(OP_XOR_IMM, 8'h62, 3'h0, 8'h5A, 8'h00);
		check(16'(accumulator_reg), 16'h005A);
	endtask

	initial begin
		#400000;
		num_errors++;
		test_done();
	end

	initial begin
		num_errors = 0;
		check_count = 0;
		reset_n = 1'b0;
		insn = '0;
		mem_rdata = 8'h00;
		high_ptr_option_en = 1'b0;
		table_pointer_low = 8'hA7;
		table_pointer_high = 4'h3;
		pc_page = 4'h9;
		rom_rdata = 16'h0000;
		repeat (12) @(posedge core_clk);
		#1;
		check(16'(accumulator_reg), 16'h0000);
		check(16'(status_flags_reg), 16'h0000);
		check(16'(mem_wr_reg.we), 16'h0000);
		check(16'(insn_ready), 16'h0001);
		reset_n = 1'b1;
		inc_dec_tests();
		bit_tests();
		sub_tests();
		move_tests();
		skip_hold_test();
		table_rd(OP_TABLE_READ_PAGE_CURRENT, 1'b1, 12'h3A7, 16'h12C4);
		table_rd(OP_TABLE_READ_PAGE_CURRENT, 1'b0, 12'h9A7, 16'h8E31);
		table_rd(OP_TABLE_READ_PAGE_LAST, 1'b1, 12'hFA7, 16'h7B09);
		xor_tests();
		reset_test();
		test_done();
	end
endmodule // mies_exec_tb_top
